// ### src/gate_delay_pkg.sv
// shared constants, codes and carriers for the gate and delay command controller
package gate_delay_pkg;

	// ===================================================================
	// register offsets (byte addresses on the backplane bus)
	localparam logic [15:0] OFS_FIRMWARE_REVISION = 16'h1000;
	localparam logic [15:0] OFS_INPUT_SETUP       = 16'h1800;
	localparam logic [15:0] OFS_CLOCK_DIVIDER     = 16'h1804;
	localparam logic [15:0] OFS_PAYLOAD_WRITE     = 16'h7F00;
	localparam logic [15:0] OFS_COMMAND_WORD      = 16'h7F04;
	localparam logic [15:0] OFS_OPERATION_START   = 16'h7F08;
	localparam logic [15:0] OFS_PAYLOAD_READ      = 16'h7F0C;
	localparam logic [15:0] OFS_CONTROLLER_STATE  = 16'h7F10;

	// ===================================================================
	// field positions
	localparam int BIT_IO_TTL     = 0;
	localparam int BIT_SRC_EXT    = 1;
	localparam int ROUTE_LSB      = 4;
	localparam int ROUTE_MSB      = 8;
	localparam int BIT_START_WR   = 0;
	localparam int BIT_START_RD   = 1;
	localparam int BIT_READY      = 0;
	localparam int STAGE_LSB      = 12;
	localparam int STAGE_MSB      = 15;
	localparam int ACT_LSB        = 8;
	localparam int ACT_MSB        = 11;
	localparam int CHAN_MSB       = 7;
	localparam int PULSE_W        = 16;

	// ===================================================================
	// reset values
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [4:0]  RST_ROUTE = 5'h00;
	localparam logic [7:0]  RST_CHAN  = 8'h00;

	// ===================================================================
	// command field codes
	localparam logic [3:0] STAGE_GATE    = 4'h2;
	localparam logic [3:0] STAGE_DELAY   = 4'h3;
	localparam logic [3:0] ACT_TRANSFER  = 4'h1;
	localparam logic [3:0] ACT_RESET     = 4'h3;
	localparam logic [3:0] ACT_CALIBRATE = 4'h4;
	localparam logic [3:0] ACT_BROADCAST = 4'h5;

	// value is arbitrary
	localparam logic [31:0] FW_REVISION = 32'h0000_0001;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_TRANSFER,
		OP_RESET,
		OP_CALIBRATE,
		OP_BROADCAST,
		OP_READ_GATE,
		OP_READ_DELAY
	} dly_op_e;

	typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} seq_state_e;

	typedef struct packed {
		dly_op_e     op;
		logic [7:0]  channel;
		logic [31:0] gate;
		logic [31:0] delay;
	} dly_cmd_s;

endpackage : gate_delay_pkg

// ### src/clock_tick_divider.sv
// divided internal clock, one leading edge every factor+1 base cycles
`timescale 1ns/100ps
`default_nettype none
module clock_tick_divider
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic [31:0] i_factor,
	output var  logic        o_tick
);
	logic [31:0] count_r;

	// ===================================================================
	// divider
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			count_r <= gate_delay_pkg::RST_WORD;
			o_tick  <= 1'b0;
		end
		else if (count_r >= i_factor)
		begin
			// factor lowered mid count restarts at once, no long wrap
			count_r <= gate_delay_pkg::RST_WORD;
			o_tick  <= 1'b1;
		end
		else
		begin
			count_r <= count_r + 32'h0000_0001;
			o_tick  <= 1'b0;
		end
	end
endmodule : clock_tick_divider
`default_nettype wire

// ### src/delayed_pulse_shaper.sv
// delayed pulse of programmable width after a leading edge event
`timescale 1ns/100ps
`default_nettype none
module delayed_pulse_shaper
(
	input  wire logic                              i_clock,
	input  wire logic                              i_rst,
	input  wire logic                              i_edge,
	input  wire logic [gate_delay_pkg::PULSE_W-1:0] i_delay,
	input  wire logic [gate_delay_pkg::PULSE_W-1:0] i_width,
	output var  logic                              o_pulse
);
	logic [gate_delay_pkg::PULSE_W-1:0] count_r;
	logic                               waiting_r;

	// ===================================================================
	// shaper; edges during a running pulse are ignored
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			count_r   <= '0;
			waiting_r <= 1'b0;
			o_pulse   <= 1'b0;
		end
		else if (!waiting_r && !o_pulse)
		begin
			if (i_edge && i_width != '0)
			begin
				waiting_r <= (i_delay != '0);
				o_pulse   <= (i_delay == '0);
				count_r   <= (i_delay != '0) ? i_delay : i_width;
			end
		end
		else if (count_r > 16'h0001)
			count_r <= count_r - 16'h0001;
		else if (waiting_r)
		begin
			waiting_r <= 1'b0;
			o_pulse   <= 1'b1;
			count_r   <= i_width;
		end
		else
			o_pulse <= 1'b0;
	end
endmodule : delayed_pulse_shaper
`default_nettype wire

// ### src/gate_delay_command_ctrl.sv
// register block and command sequencer of the gate and delay controller
`timescale 1ns/100ps
`default_nettype none
//
// Overview of operation
// - input_setup bit 1 picks divided clock (0) or trigger connector (1)
// - input_setup bit 0 selects NIM (0) or TTL (1) port levels
// - input_setup bits 8:4 hold the routing delay channel
// - internal clock divided by factor plus one; zero gives the base rate
// - pulse output delayed and sized after the selected input's leading edge
// - payload_write is the data forwarded on write commands
// - write mode: code 2 stages gate, code 3 stages delay
// - read mode: code 2 reads gate, code 3 reads delay of channel
// - action 1 transfers staged values to the selected channel
// - action 3 resets all delays, action 4 calibrates
// - action 5 broadcasts staged values to every channel
// - start bit 1 begins read, bit 0 begins write
// - read-back data lands in payload_read
// - status bit 0 is one when idle, zero when busy
// - all registers 32 bits, single accesses
// - firmware_revision reads a 32-bit revision number
module gate_delay_command_ctrl
(
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	input  wire logic [15:0]              i_addr,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	input  wire logic [31:0]              i_wdata,
	output var  logic [31:0]              o_rdata,
	output var  logic                     o_rvalid,
	input  wire logic                     i_trigger,
	output var  logic                     o_pulse,
	output var  logic                     o_io_ttl,
	output var  logic [4:0]               o_route_channel,
	output var  gate_delay_pkg::dly_cmd_s o_dly_cmd,
	output var  logic                     o_dly_valid,
	input  wire logic                     i_dly_done,
	input  wire logic [31:0]              i_dly_rdata
);
	localparam int W = gate_delay_pkg::PULSE_W;

	logic [1:0]                 setup_r;
	logic [31:0]                divider_r;
	logic [31:0]                payload_write_r;
	logic [15:0]                command_r;
	logic [1:0]                 start_r;
	logic [31:0]                payload_read_r;
	logic [31:0]                stage_gate_r;
	logic [31:0]                stage_delay_r;
	logic [W-1:0]               act_gate_r;
	logic [W-1:0]               act_delay_r;
	logic                       read_mode_r;
	logic                       trig_prev_r;
	gate_delay_pkg::seq_state_e state_r;
	gate_delay_pkg::dly_op_e    op_nxt;
	logic                       ready;
	logic                       go;
	logic                       go_rd;
	logic                       div_tick;
	logic                       sel_edge_r;
	logic [31:0]                gate_nxt;
	logic [31:0]                delay_nxt;

	// ===================================================================
	// decode helpers
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	function automatic gate_delay_pkg::dly_op_e op_of(input logic rd, input logic [15:0] cmd);
		logic [3:0] stage;
		logic [3:0] act;
		stage = cmd[gate_delay_pkg::STAGE_MSB:gate_delay_pkg::STAGE_LSB];
		act   = cmd[gate_delay_pkg::ACT_MSB:gate_delay_pkg::ACT_LSB];
		op_of = gate_delay_pkg::OP_NONE;
		if (rd)
		begin
			if (stage == gate_delay_pkg::STAGE_GATE)
				op_of = gate_delay_pkg::OP_READ_GATE;
			else if (stage == gate_delay_pkg::STAGE_DELAY)
				op_of = gate_delay_pkg::OP_READ_DELAY;
		end
		else
		begin
			case (act)
				gate_delay_pkg::ACT_TRANSFER:  op_of = gate_delay_pkg::OP_TRANSFER;
				gate_delay_pkg::ACT_RESET:     op_of = gate_delay_pkg::OP_RESET;
				gate_delay_pkg::ACT_CALIBRATE: op_of = gate_delay_pkg::OP_CALIBRATE;
				gate_delay_pkg::ACT_BROADCAST: op_of = gate_delay_pkg::OP_BROADCAST;
				default:                       op_of = gate_delay_pkg::OP_NONE;
			endcase
		end
	endfunction : op_of

	// ===================================================================
	// start detection: a write event, not the stored level
	assign ready = (state_r == gate_delay_pkg::ST_IDLE);
	assign go_rd = i_wdata[gate_delay_pkg::BIT_START_RD];
	assign go    = ready && i_wr && hit(i_addr, gate_delay_pkg::OFS_OPERATION_START)
		&& (go_rd || i_wdata[gate_delay_pkg::BIT_START_WR]);

	// ===================================================================
	// register writes
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			setup_r         <= '0;
			o_route_channel <= gate_delay_pkg::RST_ROUTE;
			o_io_ttl        <= 1'b0;
			divider_r       <= gate_delay_pkg::RST_WORD;
			payload_write_r <= gate_delay_pkg::RST_WORD;
			command_r       <= '0;
			start_r         <= '0;
		end
		else if (i_wr)
		begin
			if (hit(i_addr, gate_delay_pkg::OFS_INPUT_SETUP))
			begin
				setup_r         <= i_wdata[gate_delay_pkg::BIT_SRC_EXT:gate_delay_pkg::BIT_IO_TTL];
				o_io_ttl        <= i_wdata[gate_delay_pkg::BIT_IO_TTL];
				o_route_channel <= i_wdata[gate_delay_pkg::ROUTE_MSB:gate_delay_pkg::ROUTE_LSB];
			end
			if (hit(i_addr, gate_delay_pkg::OFS_CLOCK_DIVIDER))
				divider_r <= i_wdata;
			if (hit(i_addr, gate_delay_pkg::OFS_PAYLOAD_WRITE))
				payload_write_r <= i_wdata;
			// command word is locked while a command runs; payload_write is not
			if (hit(i_addr, gate_delay_pkg::OFS_COMMAND_WORD) && ready)
				command_r <= i_wdata[gate_delay_pkg::STAGE_MSB:0];
			if (hit(i_addr, gate_delay_pkg::OFS_OPERATION_START))
				start_r <= i_wdata[gate_delay_pkg::BIT_START_RD:gate_delay_pkg::BIT_START_WR];
		end
	end

	// ===================================================================
	// register reads, answered one cycle after the strobe
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_rdata  <= gate_delay_pkg::RST_WORD;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rvalid <= i_rd;
			o_rdata  <= gate_delay_pkg::RST_WORD;
			if (i_rd)
			begin
				case (i_addr)
					gate_delay_pkg::OFS_FIRMWARE_REVISION: o_rdata <= gate_delay_pkg::FW_REVISION;
					gate_delay_pkg::OFS_INPUT_SETUP:
						o_rdata <= {23'h000000, o_route_channel, 2'h0, setup_r};
					gate_delay_pkg::OFS_CLOCK_DIVIDER:     o_rdata <= divider_r;
					gate_delay_pkg::OFS_PAYLOAD_WRITE:     o_rdata <= payload_write_r;
					gate_delay_pkg::OFS_COMMAND_WORD:      o_rdata <= {16'h0000, command_r};
					gate_delay_pkg::OFS_OPERATION_START:   o_rdata <= {30'h00000000, start_r};
					gate_delay_pkg::OFS_PAYLOAD_READ:      o_rdata <= payload_read_r;
					gate_delay_pkg::OFS_CONTROLLER_STATE:  o_rdata <= {31'h00000000, ready};
					default:                               o_rdata <= gate_delay_pkg::RST_WORD;
				endcase
			end
		end
	end

	// ===================================================================
	// staging values as they stand after this command's write mode
	always_comb
	begin
		gate_nxt  = stage_gate_r;
		delay_nxt = stage_delay_r;
		if (!read_mode_r)
		begin
			if (command_r[gate_delay_pkg::STAGE_MSB:gate_delay_pkg::STAGE_LSB] == gate_delay_pkg::STAGE_GATE)
				gate_nxt = payload_write_r;
			if (command_r[gate_delay_pkg::STAGE_MSB:gate_delay_pkg::STAGE_LSB] == gate_delay_pkg::STAGE_DELAY)
				delay_nxt = payload_write_r;
		end
		op_nxt = op_of(read_mode_r, command_r);
	end

	// ===================================================================
	// sequencer
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_r     <= gate_delay_pkg::ST_IDLE;
			read_mode_r <= 1'b0;
			o_dly_valid <= 1'b0;
			o_dly_cmd   <= '0;
		end
		else
		begin
			o_dly_valid <= 1'b0;
			case (state_r)
				gate_delay_pkg::ST_IDLE:
					if (go)
					begin
						// read wins when both start bits are written together
						read_mode_r <= go_rd;
						state_r     <= gate_delay_pkg::ST_ISSUE;
					end
				gate_delay_pkg::ST_ISSUE:
					if (op_nxt == gate_delay_pkg::OP_NONE)
						state_r <= gate_delay_pkg::ST_IDLE;
					else
					begin
						o_dly_valid       <= 1'b1;
						o_dly_cmd.op      <= op_nxt;
						o_dly_cmd.channel <= command_r[gate_delay_pkg::CHAN_MSB:0];
						o_dly_cmd.gate    <= gate_nxt;
						o_dly_cmd.delay   <= delay_nxt;
						state_r           <= gate_delay_pkg::ST_WAIT;
					end
				gate_delay_pkg::ST_WAIT:
					if (i_dly_done)
						state_r <= gate_delay_pkg::ST_IDLE;
				default:
					state_r <= gate_delay_pkg::ST_IDLE;
			endcase
		end
	end

	// ===================================================================
	// staging buffers and read-back
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			stage_gate_r   <= gate_delay_pkg::RST_WORD;
			stage_delay_r  <= gate_delay_pkg::RST_WORD;
			payload_read_r <= gate_delay_pkg::RST_WORD;
		end
		else
		begin
			if (state_r == gate_delay_pkg::ST_ISSUE)
			begin
				stage_gate_r  <= gate_nxt;
				stage_delay_r <= delay_nxt;
			end
			if (state_r == gate_delay_pkg::ST_WAIT && i_dly_done && read_mode_r)
				payload_read_r <= i_dly_rdata;
		end
	end

	// ===================================================================
	// local copy of the values in force on the routed channel
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			act_gate_r  <= '0;
			act_delay_r <= '0;
		end
		else if (state_r == gate_delay_pkg::ST_WAIT && i_dly_done)
		begin
			if (o_dly_cmd.op == gate_delay_pkg::OP_BROADCAST
				|| (o_dly_cmd.op == gate_delay_pkg::OP_TRANSFER
				&& o_dly_cmd.channel == {3'h0, o_route_channel}))
			begin
				act_gate_r  <= o_dly_cmd.gate[W-1:0];
				act_delay_r <= o_dly_cmd.delay[W-1:0];
			end
			else if (o_dly_cmd.op == gate_delay_pkg::OP_RESET)
				act_delay_r <= '0;
		end
	end

	// ===================================================================
	// input source and pulse path
	clock_tick_divider u_div
	(
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_factor (divider_r),
		.o_tick   (div_tick)
	);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			trig_prev_r <= 1'b0;
			sel_edge_r  <= 1'b0;
		end
		else
		begin
			trig_prev_r <= i_trigger;
			sel_edge_r  <= setup_r[gate_delay_pkg::BIT_SRC_EXT] ? (i_trigger && !trig_prev_r) : div_tick;
		end
	end

	delayed_pulse_shaper u_pulse
	(
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_edge  (sel_edge_r),
		.i_delay (act_delay_r),
		.i_width (act_gate_r),
		.o_pulse (o_pulse)
	);

	// ===================================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence s_issue_write(logic [3:0] a);
		state_r == gate_delay_pkg::ST_ISSUE && !read_mode_r
			&& command_r[gate_delay_pkg::ACT_MSB:gate_delay_pkg::ACT_LSB] == a;
	endsequence

	property p_ready_drop;
		go |=> !ready ##0 (o_rdata[gate_delay_pkg::BIT_READY] == 1'b0 || !o_rvalid);
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready did not drop after start");

	property p_ready_back;
		state_r == gate_delay_pkg::ST_WAIT && i_dly_done |=> ready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("ready not restored after done");

	property p_single_issue;
		o_dly_valid |=> !o_dly_valid [*2];
	endproperty
	a_single_issue: assert property (p_single_issue) else $error("command issued twice");

	property p_transfer;
		s_issue_write(gate_delay_pkg::ACT_TRANSFER) |=> o_dly_valid && o_dly_cmd.op == gate_delay_pkg::OP_TRANSFER
			&& o_dly_cmd.channel == $past(command_r[gate_delay_pkg::CHAN_MSB:0]);
	endproperty
	a_transfer: assert property (p_transfer) else $error("transfer not issued");

	property p_broadcast;
		s_issue_write(gate_delay_pkg::ACT_BROADCAST) |=> o_dly_valid && o_dly_cmd.op == gate_delay_pkg::OP_BROADCAST;
	endproperty
	a_broadcast: assert property (p_broadcast) else $error("broadcast not issued");

	property p_maint;
		s_issue_write(gate_delay_pkg::ACT_RESET) |=> o_dly_valid && o_dly_cmd.op == gate_delay_pkg::OP_RESET;
	endproperty
	a_maint: assert property (p_maint) else $error("reset of delays not issued");

	property p_stage_gate;
		state_r == gate_delay_pkg::ST_ISSUE && !read_mode_r
			&& command_r[gate_delay_pkg::STAGE_MSB:gate_delay_pkg::STAGE_LSB] == gate_delay_pkg::STAGE_GATE
			|=> stage_gate_r == $past(payload_write_r);
	endproperty
	a_stage_gate: assert property (p_stage_gate) else $error("gate not staged");

	property p_read_back;
		state_r == gate_delay_pkg::ST_WAIT && i_dly_done && read_mode_r |=> payload_read_r == $past(i_dly_rdata);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data not captured");

	property p_read_cmd;
		go && go_rd ##1 op_nxt == gate_delay_pkg::OP_READ_DELAY |=> o_dly_cmd.op == gate_delay_pkg::OP_READ_DELAY;
	endproperty
	a_read_cmd: assert property (p_read_cmd) else $error("delay read not issued");

endmodule : gate_delay_command_ctrl
`default_nettype wire

// ### verification/delay_device_model.sv
// behavioural model of the delay logic device behind the command controller
`timescale 1ns/100ps
`default_nettype none
module delay_device_model
(
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	input  wire gate_delay_pkg::dly_cmd_s i_cmd,
	input  wire logic                     i_valid,
	input  wire logic [3:0]               i_wait,
	output var  logic                     o_done,
	output var  logic [31:0]              o_rdata
);
	// ===================================================================
	// per channel values and one outstanding command
	logic [31:0]              gate_mem  [256];
	logic [31:0]              delay_mem [256];
	gate_delay_pkg::dly_cmd_s cmd_r;
	int                       cnt_r;

	always @(posedge i_clock)
	begin
		o_done  <= 1'b0;
		// released data lines toggle so a stale value never passes for data
		o_rdata <= ~o_rdata;
		if (i_rst)
		begin
			cnt_r   <= 0;
			o_rdata <= 32'h0000_0000;
		end
		else if (i_valid)
		begin
			cmd_r <= i_cmd;
			cnt_r <= (i_wait == 4'h0) ? 1 : int'(i_wait);
		end
		else if (cnt_r > 0)
		begin
			cnt_r <= cnt_r - 1;
			if (cnt_r == 1)
			begin
				o_done <= 1'b1;
				case (cmd_r.op)
					gate_delay_pkg::OP_TRANSFER:
					begin
						gate_mem[cmd_r.channel]  <= cmd_r.gate;
						delay_mem[cmd_r.channel] <= cmd_r.delay;
					end
					gate_delay_pkg::OP_BROADCAST:
						for (int k = 0; k < 256; k++)
						begin
							gate_mem[k]  <= cmd_r.gate;
							delay_mem[k] <= cmd_r.delay;
						end
					gate_delay_pkg::OP_RESET:
						for (int k = 0; k < 256; k++)
							delay_mem[k] <= 32'h0000_0000;
					gate_delay_pkg::OP_READ_GATE: o_rdata <= gate_mem[cmd_r.channel];
					gate_delay_pkg::OP_READ_DELAY: o_rdata <= delay_mem[cmd_r.channel];
					default: ;
				endcase
			end
		end
	end
endmodule : delay_device_model
`default_nettype wire

// ### verification/gate_delay_command_ctrl_test.sv
// self-checking testbench of the gate and delay command controller
`timescale 1ns/100ps
`default_nettype none
module gate_delay_command_ctrl_test;
	// ===================================================================
	// stimulus, notes and counters
	typedef struct {logic [31:0] exp; logic [31:0] mask;} rd_note_s;
	logic                     i_clock = 1'b0;
	logic                     i_rst = 1'b1;
	logic                     i_wr = 1'b0;
	logic                     i_rd = 1'b0;
	logic                     i_trigger = 1'b0;
	logic [15:0]              i_addr = 16'h0000;
	logic [31:0]              i_wdata = 32'h0000_0000;
	logic [31:0]              o_rdata;
	logic                     o_rvalid;
	logic                     o_pulse;
	logic                     o_io_ttl;
	logic [4:0]               o_route_channel;
	gate_delay_pkg::dly_cmd_s o_dly_cmd;
	gate_delay_pkg::dly_cmd_s last_cmd;
	logic                     o_dly_valid;
	logic                     dly_done;
	logic [31:0]              dly_rdata;
	logic [3:0]               dly_wait = 4'h3;
	logic [31:0]              last_rd;
	rd_note_s                 notes[$];
	int                       n_fail = 0;
	int                       n_tests = 0;
	int                       n_valid = 0;
	int                       seed = 30997;

	always #50 i_clock = ~i_clock;

	gate_delay_command_ctrl i_gate_delay_command_ctrl (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.i_trigger(i_trigger), .o_pulse(o_pulse), .o_io_ttl(o_io_ttl), .o_route_channel(o_route_channel),
		.o_dly_cmd(o_dly_cmd), .o_dly_valid(o_dly_valid), .i_dly_done(dly_done), .i_dly_rdata(dly_rdata));

	delay_device_model i_delay_device_model (.i_clock(i_clock), .i_rst(i_rst), .i_cmd(o_dly_cmd),
		.i_valid(o_dly_valid), .i_wait(dly_wait), .o_done(dly_done), .o_rdata(dly_rdata));

	// ===================================================================
	// shared tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge i_clock);
		i_addr  = a;
		i_wdata = d;
		i_wr    = 1'b1;
		@(negedge i_clock);
		i_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
		@(negedge i_clock);
		i_addr = a;
		i_rd   = 1'b1;
		notes.push_back('{e, m});
		@(negedge i_clock);
		i_rd = 1'b0;
		@(negedge i_clock);
	endtask : rd

	task automatic wait_ready;
		for (int k = 0; k < 40; k++)
		begin
			rd(gate_delay_pkg::OFS_CONTROLLER_STATE, 32'h0, 32'h0);
			if (last_rd[0] === 1'b1)
				break;
		end
		check("ready", 32'h1, {31'h0, last_rd[0]});
	endtask : wait_ready

	task automatic command(input logic [31:0] cmd, input logic [31:0] start);
		wr(gate_delay_pkg::OFS_COMMAND_WORD, cmd);
		wr(gate_delay_pkg::OFS_OPERATION_START, start);
		wait_ready();
	endtask : command

	task automatic measure(output int rise, output int width);
		rise  = 0;
		width = 0;
		while (o_pulse !== 1'b1 && rise < 40)
		begin
			@(negedge i_clock);
			rise++;
		end
		while (o_pulse === 1'b1 && width < 40)
		begin
			@(negedge i_clock);
			width++;
		end
	endtask : measure

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	// ===================================================================
	// output watcher: takes the oldest note off the queue per read answer
	always @(posedge i_clock)
	begin
		if (o_dly_valid === 1'b1)
		begin
			n_valid++;
			last_cmd = o_dly_cmd;
		end
		if (o_rvalid === 1'b1)
		begin
			last_rd = o_rdata;
			if (notes.size() == 0)
				check("unasked read answer", 32'h0, 32'h1);
			else if (notes[0].mask != 32'h0)
				check("read data", notes[0].exp & notes[0].mask, o_rdata & notes[0].mask);
			if (notes.size() != 0)
				void'(notes.pop_front());
		end
	end

	initial
	begin
		repeat (20000) @(posedge i_clock);
		$display("watchdog expired");
		n_fail++;
		final_report();
	end

	// ===================================================================
	// main sequence
	initial
	begin
		logic [31:0] v;
		logic [31:0] g;
		logic [31:0] d;
		logic [7:0]  ch;
		int          r1;
		int          w1;
		int          r2;
		int          w2;
		int          nv;
		repeat (4) @(negedge i_clock);
		i_rst = 1'b0;
		rd(gate_delay_pkg::OFS_FIRMWARE_REVISION, gate_delay_pkg::FW_REVISION, 32'hFFFF_FFFF);
		rd(gate_delay_pkg::OFS_CONTROLLER_STATE, 32'h1, 32'hFFFF_FFFF);
		wr(gate_delay_pkg::OFS_FIRMWARE_REVISION, 32'hFFFF_FFFF);
		rd(gate_delay_pkg::OFS_FIRMWARE_REVISION, gate_delay_pkg::FW_REVISION, 32'hFFFF_FFFF);
		wr(16'h0004, $random(seed));
		rd(16'h0004, 32'h0, 32'hFFFF_FFFF);
		$display("test identity and reset state done");
		v = $random(seed);
		wr(gate_delay_pkg::OFS_INPUT_SETUP, v);
		rd(gate_delay_pkg::OFS_INPUT_SETUP, v & 32'h0000_01F3, 32'hFFFF_FFFF);
		check("io level", {31'h0, v[0]}, {31'h0, o_io_ttl});
		check("route channel", {27'h0, v[8:4]}, {27'h0, o_route_channel});
		v = $random(seed);
		wr(gate_delay_pkg::OFS_CLOCK_DIVIDER, v);
		rd(gate_delay_pkg::OFS_CLOCK_DIVIDER, v, 32'hFFFF_FFFF);
		wr(gate_delay_pkg::OFS_COMMAND_WORD, v);
		rd(gate_delay_pkg::OFS_COMMAND_WORD, v & 32'h0000_FFFF, 32'hFFFF_FFFF);
		wr(gate_delay_pkg::OFS_OPERATION_START, 32'hFFFF_FFFC);
		rd(gate_delay_pkg::OFS_OPERATION_START, 32'h0, 32'hFFFF_FFFF);
		$display("test setup registers done");
		ch = {3'h0, 5'($random(seed))};
		g  = {16'($random(seed)), 16'h0003};
		d  = {16'($random(seed)), 16'h0002};
		wr(gate_delay_pkg::OFS_INPUT_SETUP, {23'h0, ch[4:0], 4'h2});
		wr(gate_delay_pkg::OFS_PAYLOAD_WRITE, g);
		rd(gate_delay_pkg::OFS_PAYLOAD_WRITE, g, 32'hFFFF_FFFF);
		command({16'h0, gate_delay_pkg::STAGE_GATE, 4'h0, ch}, 32'h1);
		wr(gate_delay_pkg::OFS_PAYLOAD_WRITE, d);
		command({16'h0, gate_delay_pkg::STAGE_DELAY, 4'h0, ch}, 32'h1);
		dly_wait = 4'hF;
		nv = n_valid;
		wr(gate_delay_pkg::OFS_COMMAND_WORD, {16'h0, 4'h0, gate_delay_pkg::ACT_TRANSFER, ch});
		wr(gate_delay_pkg::OFS_OPERATION_START, 32'h1);
		rd(gate_delay_pkg::OFS_CONTROLLER_STATE, 32'h0, 32'h1);
		wr(gate_delay_pkg::OFS_OPERATION_START, 32'h1);
		wait_ready();
		repeat (10) @(negedge i_clock);
		check("command count", 32'h1, 32'(n_valid - nv));
		check("op", {29'h0, gate_delay_pkg::OP_TRANSFER}, {29'h0, last_cmd.op});
		check("channel", {24'h0, ch}, {24'h0, last_cmd.channel});
		check("gate", g, last_cmd.gate);
		check("delay", d, last_cmd.delay);
		$display("test staging and transfer done");
		dly_wait = 4'($random(seed));
		command({16'h0, gate_delay_pkg::STAGE_GATE, 4'h0, ch}, 32'h2);
		check("op", {29'h0, gate_delay_pkg::OP_READ_GATE}, {29'h0, last_cmd.op});
		rd(gate_delay_pkg::OFS_PAYLOAD_READ, g, 32'hFFFF_FFFF);
		command({16'h0, gate_delay_pkg::STAGE_DELAY, 4'h0, ch}, 32'h3);
		check("op", {29'h0, gate_delay_pkg::OP_READ_DELAY}, {29'h0, last_cmd.op});
		rd(gate_delay_pkg::OFS_PAYLOAD_READ, d, 32'hFFFF_FFFF);
		$display("test read back done");
		@(negedge i_clock);
		i_trigger = 1'b1;
		measure(r1, w1);
		i_trigger = 1'b0;
		check("pulse width", 32'h3, 32'(w1));
		check("pulse delay ok", 32'h1, {31'h0, r1 >= 2 && r1 <= 5});
		wr(gate_delay_pkg::OFS_CLOCK_DIVIDER, 32'h0000_0009);
		wr(gate_delay_pkg::OFS_INPUT_SETUP, {23'h0, ch[4:0], 4'h1});
		measure(r1, w1);
		measure(r2, w2);
		check("clock period", 32'hA, 32'(w1 + r2));
		check("clock pulse width", 32'h3, 32'(w2));
		$display("test pulse output done");
		command({16'h0, 4'h0, gate_delay_pkg::ACT_RESET, ch}, 32'h1);
		check("op", {29'h0, gate_delay_pkg::OP_RESET}, {29'h0, last_cmd.op});
		command({16'h0, 4'h0, gate_delay_pkg::ACT_CALIBRATE, ch}, 32'h1);
		check("op", {29'h0, gate_delay_pkg::OP_CALIBRATE}, {29'h0, last_cmd.op});
		command({16'h0, 4'h0, gate_delay_pkg::ACT_BROADCAST, ch}, 32'h1);
		check("op", {29'h0, gate_delay_pkg::OP_BROADCAST}, {29'h0, last_cmd.op});
		check("broadcast gate", g, last_cmd.gate);
		$display("test maintenance actions done");
		final_report();
	end
endmodule : gate_delay_command_ctrl_test
`default_nettype wire
